/* design/pirq_pkg.sv */
// constants for the peripheral interrupt flag and enable block
// Summary of operation
// - timer three overflow sets flag bit 1; stays set until software writes zero
// - capture in capture mode or compare match in compare mode sets capcomp two flag bit 0; software clears
// - with priority scheme off, nothing reaches core without peripheral global enable
// - enable bit 7 gates the parallel slave port read/write interrupt
// - enable bit 6 gates the converter completion interrupt
// - enable bit 5 gates the serial receive interrupt
// - enable bit 4 gates the serial transmit interrupt
// - enable bit 3 gates the synchronous serial port interrupt
// - enable bit 2 gates the capcomp unit one interrupt
// - enable bit 1 gates the timer two period match interrupt
// - enable bit 0 gates the timer one overflow interrupt
package pirq_pkg;
  localparam logic [3:0] OFS_ENABLE_ONE = 4'h0;
  localparam logic [3:0] OFS_FLAG_TWO   = 4'h4;
  localparam logic [3:0] OFS_CONTROL    = 4'h8;
  localparam logic [3:0] OFS_SRC_ONE    = 4'hc;
  localparam int         BIT_CAPCOMP_TWO = 0;
  localparam int         BIT_TIMER_THREE = 1;
  localparam int         BIT_GLOBAL     = 0;
  localparam int         BIT_PRIO       = 1;
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [7:0] FLAG_TWO_MASK  = 8'h03;
  localparam logic [1:0] CC_MODE_OFF     = 2'h0;
  localparam logic [1:0] CC_MODE_CAPTURE = 2'h1;
  localparam logic [1:0] CC_MODE_COMPARE = 2'h2;
  localparam logic [1:0] CC_MODE_PWM     = 2'h3;
endpackage

/* design/peripheral_interrupt_flag_enable.sv */
// peripheral interrupt flag and enable logic with a wishbone slave
`timescale 1ns/1ps
`default_nettype none
module peripheral_interrupt_flag_enable
  import pirq_pkg::*;
#(
  // number of level sources behind the first enable register
  parameter int SRC_COUNT = 8
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [3:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]     wb_dat_o,
  output logic            wb_ack_o,
  input  wire logic [7:0] src_one_i,
  input  wire logic       timer_three_ovf_i,
  input  wire logic       cc_capture_i,
  input  wire logic       cc_compare_i,
  input  wire logic [1:0] cc_mode_i,
  output logic            irq_o
);
  logic [7:0] enable_one_r;
  logic [1:0] flag_two_r;
  logic [1:0] control_r;
  logic [7:0] src_one_r;
  logic       irq_nxt;
  logic       wr_stb;
  logic       cc_event;
  // per-source request bits after their individual enable
  logic [SRC_COUNT-1:0] src_gated;
  logic                 any_src_req;
  logic                 any_flag_req;
  logic                 gate_open;

  // the enable, source and readback paths are one byte wide and the bus
  // only carries byte 0, so another source count would need a wider
  // register map rather than a longer loop; refuse it at elaboration
  if (SRC_COUNT != 8)
  begin : g_count_check
    $error("SRC_COUNT must be 8 for this register map");
  end

  // a write is taken once per request, on the edge that raises ack;
  // lanes other than byte 0 carry nothing, so sel[0] alone qualifies it
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

  // one-cycle ack, dropped the cycle after; a master that keeps its
  // strobe up past the ack is not taken twice, since the low ack is
  // part of the take condition; the fixed single wait state keeps the
  // read mux registered without a second pipeline stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  // enable and control registers; bit 7 of the enable byte is stored
  // as written even on parts without a parallel slave port, keeping it
  // clear there is left to software
  // control holds the global enable and the priority scheme enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enable_one_r <= RST_BYTE;
      control_r    <= 2'h0;
    end
    else if (wr_stb)
    begin
      if (wb_adr_i == OFS_ENABLE_ONE)
        enable_one_r <= wb_dat_i[7:0];
      if (wb_adr_i == OFS_CONTROL)
        control_r <= wb_dat_i[1:0];
    end
  end

  // pwm mode never touches the flag; off mode neither, since the unit
  // then reports nothing meaningful and a stray pulse must not latch
  // the decode uses the live mode so a mode change acts at once
  assign cc_event = ((cc_mode_i == CC_MODE_CAPTURE) && cc_capture_i)
                 || ((cc_mode_i == CC_MODE_COMPARE) && cc_compare_i);

  // flags: hardware set wins over a software write of zero
  // the set terms come last so they override the write in one edge;
  // losing an event to a clear in the same cycle would hide it forever
  // a write of one also sets a flag, which lets software test the path
  // both flags are sticky: only a write ever takes them down
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_two_r <= 2'h0;
    else
    begin
      if (wr_stb && wb_adr_i == OFS_FLAG_TWO)
        flag_two_r <= wb_dat_i[1:0];
      if (timer_three_ovf_i)
        flag_two_r[BIT_TIMER_THREE] <= 1'b1;
      if (cc_event)
        flag_two_r[BIT_CAPCOMP_TWO] <= 1'b1;
    end
  end

  // sampled level flags from the first-register sources
  // these are levels owned by their peripherals, so they are not
  // sticky here; one register stage costs a cycle of request latency
  // but keeps the gating off the raw pins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      src_one_r <= RST_BYTE;
    else
      src_one_r <= src_one_i;
  end

  // per-source gating, one enable bit per source level; bit 7 is the
  // parallel slave port, 6 the converter, 5 and 4 serial receive and
  // transmit, 3 the sync serial port, 2 capcomp one, 1 the timer two
  // period match and 0 the timer one overflow
  for (genvar g = 0; g < SRC_COUNT; g++)
  begin : g_src_gate
    assign src_gated[g] = src_one_r[g] & enable_one_r[g];
  end

  // any gated source or any second-register flag; the second enable
  // register is not part of this block, so its flags request directly
  assign any_src_req  = |src_gated;
  assign any_flag_req = |flag_two_r;

  // with the priority scheme on the global enable is skipped, otherwise
  // it must be set for anything to reach the core
  assign gate_open = control_r[BIT_PRIO] || control_r[BIT_GLOBAL];

  // request: gated sources and flags, held back while the gate is shut
  always_comb
  begin
    irq_nxt = any_src_req || any_flag_req;
    if (!gate_open)
      irq_nxt = 1'b0;
  end

  // registered so the pin comes straight from a flip-flop and never
  // glitches while the enables and flags change underneath it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= irq_nxt;
  end

  // read mux, unmapped reads return zero
  // the mux runs every cycle on the live address; the master only takes
  // it in the ack cycle, when it holds the value of the taken request
  // upper lanes always read zero since only byte 0 is implemented
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0;
    else
    begin
      unique case (wb_adr_i)
        OFS_ENABLE_ONE: wb_dat_o <= {24'h0, enable_one_r};
        OFS_FLAG_TWO:   wb_dat_o <= {30'h0, flag_two_r};
        OFS_CONTROL:    wb_dat_o <= {30'h0, control_r};
        OFS_SRC_ONE:    wb_dat_o <= {24'h0, src_one_r};
        default:        wb_dat_o <= 32'h0;
      endcase
    end
  end

  // checks on what this block drives; every property is on clk_i and
  // switched off during reset, since the registers are being cleared
  // then and the inputs may still be settling
  // the bus answer: a request taken while ack is low is acked next edge
  sequence wb_take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence wb_answer_s;
    ##1 wb_ack_o;
  endsequence

  // a software write that lands on the flag register this edge
  sequence flag_write_s;
    wr_stb && (wb_adr_i == OFS_FLAG_TWO);
  endsequence

  // timer three overflow sets its flag on the next edge
  timer_three_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    timer_three_ovf_i |=> flag_two_r[BIT_TIMER_THREE])
    else $error("timer three flag not set");

  // once set, only a software write may take the timer three flag down
  timer_three_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (flag_two_r[BIT_TIMER_THREE] && !(wr_stb && wb_adr_i == OFS_FLAG_TWO))
    |=> flag_two_r[BIT_TIMER_THREE])
    else $error("timer three flag dropped");

  // a write of zero clears the timer three flag unless an overflow collides
  timer_three_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (flag_write_s ##0 (!wb_dat_i[BIT_TIMER_THREE] && !timer_three_ovf_i))
    |=> !flag_two_r[BIT_TIMER_THREE])
    else $error("timer three flag not cleared");

  // a capture in capture mode sets the capcomp two flag
  cc_capture_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cc_mode_i == CC_MODE_CAPTURE && cc_capture_i) |=> flag_two_r[BIT_CAPCOMP_TWO])
    else $error("capture did not set flag");

  // a match in compare mode sets the same flag
  cc_compare_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cc_mode_i == CC_MODE_COMPARE && cc_compare_i) |=> flag_two_r[BIT_CAPCOMP_TWO])
    else $error("compare did not set flag");

  // the capcomp two flag is sticky until software writes it
  cc_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (flag_two_r[BIT_CAPCOMP_TWO] && !(wr_stb && wb_adr_i == OFS_FLAG_TWO))
    |=> flag_two_r[BIT_CAPCOMP_TWO])
    else $error("capcomp flag dropped");

  // a write of zero clears the capcomp two flag unless an event collides
  cc_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (flag_write_s ##0 (!wb_dat_i[BIT_CAPCOMP_TWO] && !cc_event))
    |=> !flag_two_r[BIT_CAPCOMP_TWO])
    else $error("capcomp flag not cleared");

  // pwm mode leaves the flag alone whatever the unit reports
  pwm_quiet_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cc_mode_i == CC_MODE_PWM && !flag_two_r[BIT_CAPCOMP_TWO] && !wr_stb)
    |=> !flag_two_r[BIT_CAPCOMP_TWO])
    else $error("pwm set flag");

  // nothing leaves while both the priority scheme and global enable are off
  global_gate_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (control_r == 2'h0) |=> !irq_o)
    else $error("irq without global enable");

  // with the priority scheme on, a pending flag goes out without the gate
  prio_skip_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (control_r[BIT_PRIO] && flag_two_r != 2'h0) |=> irq_o)
    else $error("priority scheme did not bypass gate");

  // a lone bit 7 source follows its enable bit
  bit7_en_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (gate_open && flag_two_r == 2'h0 && src_one_r == 8'h80)
    |=> irq_o == $past(enable_one_r[7]))
    else $error("bit 7 gating wrong");

  // a lone bit 0 source follows its enable bit
  bit0_en_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (gate_open && flag_two_r == 2'h0 && src_one_r == 8'h01)
    |=> irq_o == $past(enable_one_r[0]))
    else $error("bit 0 gating wrong");

  // any gated source with the gate open raises the request
  any_req_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (gate_open && |(src_one_r & enable_one_r)) |=> irq_o)
    else $error("request missing");

  // no request while nothing is pending
  no_req_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ((src_one_r & enable_one_r) == 8'h00 && flag_two_r == 2'h0) |=> !irq_o)
    else $error("request without a pending source");

  // a write to the enable register lands byte 0 intact
  enable_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_stb && wb_adr_i == OFS_ENABLE_ONE) |=> enable_one_r == $past(wb_dat_i[7:0]))
    else $error("enable write lost");

  // every taken request is answered exactly one edge later
  ack_follow_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_take_s |-> wb_answer_s)
    else $error("request not answered");

  // ack is a single-cycle pulse, so a held strobe is not taken twice
  ack_pulse_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule // peripheral_interrupt_flag_enable
`default_nettype wire

/* test/periph_model.sv */
// peripheral event source model feeding the flag inputs
`timescale 1ns/1ps
`default_nettype none
module periph_model (
  input  wire logic       clk_i,
  input  wire logic [2:0] fire_i,
  output logic [2:0]      ev_o
);
  // single-cycle event pulses, launched one edge after the request
  always_ff @(posedge clk_i)
    ev_o <= fire_i;
endmodule // periph_model
`default_nettype wire

/* test/peripheral_interrupt_flag_enable_tb_top.sv */
// self-checking bench for the peripheral interrupt flag and enable block
`timescale 1ns/1ps
`default_nettype none
module peripheral_interrupt_flag_enable_tb_top;
  import pirq_pkg::*;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, irq;
  logic [3:0]  adr = 4'h0;
  logic [31:0] dat = 32'h0, rd, q;
  logic [7:0]  src = 8'h00;
  logic [1:0]  mode = 2'h0;
  logic [2:0]  fire = 3'h0, ev;
  logic [15:0] lf = 16'h45f4;
  int          bad_count, num_checks, tick, en, fl, ctl;
  always #4 clk = ~clk;
  periph_model pm (.clk_i(clk), .fire_i(fire), .ev_o(ev));
  peripheral_interrupt_flag_enable dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(rd), .wb_ack_o(ack), .src_one_i(src), .timer_three_ovf_i(ev[0]),
    .cc_capture_i(ev[1]), .cc_compare_i(ev[2]), .cc_mode_i(mode), .irq_o(irq));
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    tick++;
    if (tick == 5000)
    begin
      bad_count++;
      results();
    end
  end
  // classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input int d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= 32'(d);
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rd;
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] s, input int e);
    num_checks++;
    if (s !== 32'(e))
    begin
      bad_count++;
      $display("wrong value at %0t: %h not %h", $time, s, e);
    end
  endtask
  // irq lags events by two edges, so settle first
  task automatic irq_chk();
    repeat (4) @(posedge clk);
    chk(irq, ((en & src) != 0 || fl != 0) && ctl != 0);
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    wb(0, OFS_ENABLE_ONE, 0);
    chk(q, 0);
    $display("reset test done");
    // each enable alone; second pass drives that source alone
    for (int i = 0; i < 16; i++)
    begin
      ctl = (2 * i + 1) % 3;
      en = 1 << (i % 8);
      lf = nx(lf);
      src <= i < 8 ? lf[7:0] : 8'(en);
      wb(1, OFS_CONTROL, ctl);
      wb(1, OFS_ENABLE_ONE, en);
      wb(0, OFS_ENABLE_ONE, 0);
      chk(q, en);
      irq_chk();
    end
    $display("enable test done");
    en = 0;
    ctl = 1;
    wb(1, OFS_ENABLE_ONE, 0);
    // modes pwm, compare, capture with capcomp events, then off with a timer three overflow
    for (int k = 0; k < 4; k++)
    begin
      ctl = 1 + k % 2;
      wb(1, OFS_CONTROL, ctl);
      mode <= 2'(3 - k);
      fire <= 3'(k == 3 ? 1 : (k == 0 ? 6 : 6 - 2 * k));
      fl = k == 0 ? 0 : (k == 3 ? 2 : 1);
      @(posedge clk);
      fire <= 0;
      irq_chk();
      wb(0, OFS_FLAG_TWO, 0);
      chk(q, fl);
      wb(1, OFS_FLAG_TWO, 0);
      fl = 0;
      irq_chk();
    end
    $display("flag test done");
    results();
  end
endmodule // peripheral_interrupt_flag_enable_tb_top
`default_nettype wire
